// [hw/gpc_pkg.sv]
/*
  Package for the three-port GPIO block with change detection.
  Holds register offsets, reset values, field positions and carrier structs.
  Assumes a byte-wide register port with 9-bit addresses.
*/
package gpc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [8:0] PORT_A_PIN_DATA_ADDR   = 9'h005;
  localparam logic [8:0] PORT_B_PIN_DATA_ADDR   = 9'h006;
  localparam logic [8:0] PORT_C_PIN_DATA_ADDR   = 9'h007;
  localparam logic [8:0] OPTIONS_ADDR           = 9'h081;
  localparam logic [8:0] PORT_A_DIRECTION_ADDR  = 9'h085;
  localparam logic [8:0] PORT_B_DIRECTION_ADDR  = 9'h086;
  localparam logic [8:0] PORT_C_DIRECTION_ADDR  = 9'h087;
  localparam logic [8:0] ANALOG_PIN_CONFIG_ADDR = 9'h09F;
  localparam logic [8:0] INTERRUPT_CONTROL_ADDR = 9'h00B;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] OPTIONS_RST           = 8'hFF;
  localparam logic [5:0] PORT_A_DIRECTION_RST  = 6'h3F;
  localparam logic [7:0] PORT_B_DIRECTION_RST  = 8'hFF;
  localparam logic [5:0] PORT_C_DIRECTION_RST  = 6'h3F;
  localparam logic [2:0] ANALOG_PIN_CONFIG_RST = 3'h0;
  localparam logic [7:0] ZERO_BYTE             = 8'h00;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int PULLUP_DISABLE_N_BIT = 7;
  localparam int IRQ_EDGE_SELECT_BIT  = 6;
  localparam int PORT_CHANGE_FLAG_BIT = 0;
  localparam int CHANGE_LO_BIT        = 4;
  localparam int CHANGE_PINS          = 4;
  localparam int NARROW_W             = 6;
  localparam int WIDE_W               = 8;
  localparam int CFG_W                = 3;

  // Analog config: code 0 makes all six port A pins analog, 7 all digital
  localparam logic [CFG_W-1:0] CFG_ALL_ANALOG = 3'h0;
  localparam logic [CFG_W-1:0] CFG_LOW4_ANA   = 3'h4;
  localparam logic [CFG_W-1:0] CFG_LOW2_ANA   = 3'h5;
  localparam logic [CFG_W-1:0] CFG_ALL_DIGITAL = 3'h7;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpc_bus_s;

  typedef struct packed {
    logic [NARROW_W-1:0] drive;
    logic [NARROW_W-1:0] oe_n;
  } gpc_pins6_s;

  typedef struct packed {
    logic [WIDE_W-1:0] drive;
    logic [WIDE_W-1:0] oe_n;
    logic [WIDE_W-1:0] pullup_en;
  } gpc_pins8_s;

endpackage

// [hw/gpc_change_detect.sv]
/*
  Change detector for the upper port B pins.
  Assumes pin inputs synchronous to the clock and a refresh pulse on port B access.
*/
`timescale 1ns/1ps
`default_nettype none

module gpc_change_detect #(
  parameter int PINS = 4
) (
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic [PINS-1:0] pins,
  input  wire logic [PINS-1:0] is_input,
  input  wire logic            refresh,
  output logic                 mismatch
);

  logic [PINS-1:0] snap_reg;
  logic [PINS-1:0] diff;

  // ****************************************
  // Snapshot and compare
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      snap_reg <= '0;
    end else if (refresh) begin
      snap_reg <= pins;
    end
  end

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_cmp
      assign diff[i] = is_input[i] & (pins[i] ^ snap_reg[i]);
    end
  endgenerate

  assign mismatch = |diff;

endmodule

`default_nettype wire

// [hw/gpc_gpio_ports.sv]
/*
  Three-port GPIO: port A (6 bits, analog/alternate), port B (8 bits, pull-ups,
  change detect, external interrupt input), port C (6 bits, peripheral override).
  Assumes a single-cycle register port and pins synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module gpc_gpio_ports #(
  parameter int A_W = 6,
  parameter int B_W = 8,
  parameter int C_W = 6
) (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire gpc_pkg::gpc_bus_s     bus,
  output logic [7:0]                 rdata,
  input  wire logic [A_W-1:0]        port_a_in,
  output gpc_pkg::gpc_pins6_s        port_a_out,
  output logic [A_W-1:0]             port_a_analog_sel,
  output logic                       timer_ext_clock_in,
  output logic                       serial_slave_select,
  input  wire logic [B_W-1:0]        port_b_in,
  output gpc_pkg::gpc_pins8_s        port_b_out,
  output logic                       ext_irq_in,
  output logic                       irq_edge_select,
  output logic                       wake_event,
  output logic                       port_change_flag,
  input  wire logic [C_W-1:0]        port_c_in,
  output gpc_pkg::gpc_pins6_s        port_c_out,
  input  wire logic [C_W-1:0]        periph_override_en,
  input  wire logic [C_W-1:0]        periph_override_in,
  input  wire logic [C_W-1:0]        periph_out
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [A_W-1:0]            port_a_latch_reg;
  logic [B_W-1:0]            port_b_latch_reg;
  logic [C_W-1:0]            port_c_latch_reg;
  logic [A_W-1:0]            port_a_direction_reg;
  logic [B_W-1:0]            port_b_direction_reg;
  logic [C_W-1:0]            port_c_direction_reg;
  logic [7:0]                options_reg;
  logic [gpc_pkg::CFG_W-1:0] analog_pin_config_reg;
  logic                      port_change_flag_reg;
  logic [7:0]                rdata_reg;

  logic wr_a, wr_b, wr_c, wr_opt, wr_da, wr_db, wr_dc, wr_cfg, wr_ic;
  logic rd_b;

  assign wr_a   = bus.wr && bus.addr == gpc_pkg::PORT_A_PIN_DATA_ADDR;
  assign wr_b   = bus.wr && bus.addr == gpc_pkg::PORT_B_PIN_DATA_ADDR;
  assign wr_c   = bus.wr && bus.addr == gpc_pkg::PORT_C_PIN_DATA_ADDR;
  assign wr_opt = bus.wr && bus.addr == gpc_pkg::OPTIONS_ADDR;
  assign wr_da  = bus.wr && bus.addr == gpc_pkg::PORT_A_DIRECTION_ADDR;
  assign wr_db  = bus.wr && bus.addr == gpc_pkg::PORT_B_DIRECTION_ADDR;
  assign wr_dc  = bus.wr && bus.addr == gpc_pkg::PORT_C_DIRECTION_ADDR;
  assign wr_cfg = bus.wr && bus.addr == gpc_pkg::ANALOG_PIN_CONFIG_ADDR;
  assign wr_ic  = bus.wr && bus.addr == gpc_pkg::INTERRUPT_CONTROL_ADDR;
  assign rd_b   = bus.rd && bus.addr == gpc_pkg::PORT_B_PIN_DATA_ADDR;

  // ****************************************
  // Analog selection on port A
  // ****************************************
  logic [A_W-1:0] analog_mask;

  always_comb begin
    unique case (analog_pin_config_reg)
      gpc_pkg::CFG_ALL_ANALOG:  analog_mask = '1;
      gpc_pkg::CFG_LOW4_ANA:    analog_mask = A_W'(6'h0F);
      gpc_pkg::CFG_LOW2_ANA:    analog_mask = A_W'(6'h03);
      gpc_pkg::CFG_ALL_DIGITAL: analog_mask = '0;
      default:                  analog_mask = A_W'(6'h2F);
    endcase
  end

  assign port_a_analog_sel = analog_mask;

  // Digital view of the pins; analog pins read as zero
  logic [A_W-1:0] port_a_view;
  logic [C_W-1:0] port_c_dir_eff;

  assign port_a_view = port_a_in & ~analog_mask;

  // ****************************************
  // Port latches, read-modify-write of sampled pins
  // ****************************************
  // Writes load the whole byte; sampling pins first means a bit-wise
  // instruction in the core sees pin levels, which is the classic hazard.
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      port_a_latch_reg <= '0;
      port_b_latch_reg <= '0;
      port_c_latch_reg <= '0;
    end else begin
      if (wr_a) begin
        port_a_latch_reg <= bus.wdata[A_W-1:0];
      end
      if (wr_b) begin
        port_b_latch_reg <= bus.wdata[B_W-1:0];
      end
      if (wr_c) begin
        port_c_latch_reg <= bus.wdata[C_W-1:0];
      end
    end
  end

  // ****************************************
  // Direction, option and config registers
  // ****************************************
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      port_a_direction_reg  <= gpc_pkg::PORT_A_DIRECTION_RST;
      port_b_direction_reg  <= gpc_pkg::PORT_B_DIRECTION_RST;
      port_c_direction_reg  <= gpc_pkg::PORT_C_DIRECTION_RST;
      options_reg           <= gpc_pkg::OPTIONS_RST;
      analog_pin_config_reg <= gpc_pkg::ANALOG_PIN_CONFIG_RST;
    end else begin
      if (wr_da) begin
        port_a_direction_reg <= bus.wdata[A_W-1:0];
      end
      if (wr_db) begin
        port_b_direction_reg <= bus.wdata[B_W-1:0];
      end
      if (wr_dc) begin
        port_c_direction_reg <= bus.wdata[C_W-1:0];
      end
      if (wr_opt) begin
        options_reg <= bus.wdata;
      end
      if (wr_cfg) begin
        analog_pin_config_reg <= bus.wdata[gpc_pkg::CFG_W-1:0];
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  logic [B_W-1:0] pullups;

  always_comb begin
    port_a_out.drive = port_a_latch_reg;
    port_a_out.oe_n  = port_a_direction_reg;
    // Open drain: only a low latch bit may enable the driver
    port_a_out.drive[4] = 1'b0;
    port_a_out.oe_n[4]  = port_a_direction_reg[4] | port_a_latch_reg[4];
  end

  // Direction 1 means high impedance, so the direction bit is the active-low enable
  always_comb begin
    port_b_out.drive     = port_b_latch_reg;
    port_b_out.oe_n      = port_b_direction_reg;
    port_b_out.pullup_en = pullups;
  end

  assign pullups = {B_W{~options_reg[gpc_pkg::PULLUP_DISABLE_N_BIT]}}
                   & port_b_direction_reg;

  // Override wins over the software bit only while the peripheral is on
  assign port_c_dir_eff = (port_c_direction_reg & ~periph_override_en)
                          | (periph_override_in & periph_override_en);

  always_comb begin
    port_c_out.drive = (port_c_latch_reg & ~periph_override_en)
                       | (periph_out & periph_override_en);
    port_c_out.oe_n  = port_c_dir_eff;
  end

  // ****************************************
  // Alternate inputs
  // ****************************************
  assign timer_ext_clock_in  = port_a_in[4];
  assign serial_slave_select = port_a_in[5];
  assign ext_irq_in          = port_b_in[0];
  assign irq_edge_select     = options_reg[gpc_pkg::IRQ_EDGE_SELECT_BIT];

  // ****************************************
  // Change detection
  // ****************************************
  logic change_mismatch;

  gpc_change_detect #(
    .PINS (gpc_pkg::CHANGE_PINS)
  ) u_change (
    .clock    (clock),
    .rst_n    (rst_n_reg),
    .pins     (port_b_in[B_W-1:gpc_pkg::CHANGE_LO_BIT]),
    .is_input (port_b_direction_reg[B_W-1:gpc_pkg::CHANGE_LO_BIT]),
    .refresh  (rd_b | wr_b),
    .mismatch (change_mismatch)
  );

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      port_change_flag_reg <= 1'b0;
    end else if (change_mismatch) begin
      port_change_flag_reg <= 1'b1;
    end else if (wr_ic) begin
      port_change_flag_reg <= bus.wdata[gpc_pkg::PORT_CHANGE_FLAG_BIT];
    end
  end

  assign port_change_flag = port_change_flag_reg;
  assign wake_event       = change_mismatch;

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = gpc_pkg::ZERO_BYTE;
    unique case (bus.addr)
      gpc_pkg::PORT_A_PIN_DATA_ADDR:   rdata_next[A_W-1:0] = port_a_view;
      gpc_pkg::PORT_B_PIN_DATA_ADDR:   rdata_next[B_W-1:0] = port_b_in;
      gpc_pkg::PORT_C_PIN_DATA_ADDR:   rdata_next[C_W-1:0] = port_c_in;
      gpc_pkg::OPTIONS_ADDR:           rdata_next = options_reg;
      gpc_pkg::PORT_A_DIRECTION_ADDR:  rdata_next[A_W-1:0] = port_a_direction_reg;
      gpc_pkg::PORT_B_DIRECTION_ADDR:  rdata_next[B_W-1:0] = port_b_direction_reg;
      gpc_pkg::PORT_C_DIRECTION_ADDR:  rdata_next[C_W-1:0] = port_c_direction_reg;
      gpc_pkg::ANALOG_PIN_CONFIG_ADDR: rdata_next[gpc_pkg::CFG_W-1:0] = analog_pin_config_reg;
      gpc_pkg::INTERRUPT_CONTROL_ADDR: rdata_next[gpc_pkg::PORT_CHANGE_FLAG_BIT] = port_change_flag_reg;
      default:                         rdata_next = gpc_pkg::ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= gpc_pkg::ZERO_BYTE;
    end else if (bus.rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= gpc_pkg::ZERO_BYTE;
    end
  end

  assign rdata = rdata_reg;

endmodule

`default_nettype wire

// [verification/gpc_gpio_ports_assertions.sv]
/*
  Checker for the three-port GPIO block.
  Assumes it is bound to gpc_gpio_ports and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module gpc_gpio_ports_checker #(
  parameter int A_W = 6,
  parameter int B_W = 8,
  parameter int C_W = 6
) (
  input wire logic               clock,
  input wire logic               arst_n,
  input wire gpc_pkg::gpc_bus_s  bus,
  input wire logic [7:0]         rdata,
  input wire logic [A_W-1:0]     port_a_in,
  input wire gpc_pkg::gpc_pins6_s port_a_out,
  input wire logic               timer_ext_clock_in,
  input wire logic               serial_slave_select,
  input wire logic [B_W-1:0]     port_b_in,
  input wire gpc_pkg::gpc_pins8_s port_b_out,
  input wire logic               ext_irq_in,
  input wire logic               wake_event,
  input wire logic               port_change_flag,
  input wire gpc_pkg::gpc_pins6_s port_c_out,
  input wire logic [C_W-1:0]     periph_override_en,
  input wire logic [C_W-1:0]     periph_override_in,
  input wire logic [C_W-1:0]     periph_out
);
  // Cycles since reset release; the core holds its own reset two more edges
  logic [1:0] age;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read");
  a_pullup_outoff: assert property ((port_b_out.pullup_en & ~port_b_out.oe_n) == 8'h00)
    else $error("pull-up on output pin");
  a_pullup_global: assert property (bus.wr && bus.addr == gpc_pkg::OPTIONS_ADDR && !bus.wdata[7]
    |=> port_b_out.pullup_en == port_b_out.oe_n) else $error("pull-ups not enabled");
  a_pullup_disable: assert property (bus.wr && bus.addr == gpc_pkg::OPTIONS_ADDR && bus.wdata[7]
    |=> port_b_out.pullup_en == 8'h00) else $error("pull-ups not disabled");
  a_flag_set: assert property (age == 2'h3 && wake_event |=> port_change_flag)
    else $error("flag not set on mismatch");
  a_flag_sticky: assert property (port_change_flag && !(bus.wr && bus.addr == gpc_pkg::INTERRUPT_CONTROL_ADDR)
    |=> port_change_flag) else $error("flag dropped by itself");
  a_clear_refused: assert property (age == 2'h3 && wake_event && bus.wr
    && bus.addr == gpc_pkg::INTERRUPT_CONTROL_ADDR |=> port_change_flag) else $error("flag cleared in mismatch");
  a_refresh_ends: assert property (age == 2'h3 && (bus.rd || bus.wr) && bus.addr == gpc_pkg::PORT_B_PIN_DATA_ADDR
    ##1 $stable(port_b_in) |-> !wake_event) else $error("mismatch survived port access");
  a_override_pins: assert property (((port_c_out.oe_n ^ periph_override_in) & periph_override_en) == '0
    && ((port_c_out.drive ^ periph_out) & periph_override_en) == '0) else $error("override ignored");
  a_open_drain: assert property (!port_a_out.drive[4])
    else $error("open drain pin driven high");
  a_alt_inputs: assert property (timer_ext_clock_in == port_a_in[4] && serial_slave_select == port_a_in[5]
    && ext_irq_in == port_b_in[0]) else $error("alternate input not passed");
  c_change: cover property (wake_event ##1 port_change_flag);
  c_override: cover property (periph_override_en != '0);
  c_pullup: cover property (port_b_out.pullup_en != 8'h00);
endmodule
bind gpc_gpio_ports gpc_gpio_ports_checker #(.A_W(A_W), .B_W(B_W), .C_W(C_W)) i_gpc_gpio_ports_checker (
  .clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata), .port_a_in(port_a_in), .port_a_out(port_a_out),
  .timer_ext_clock_in(timer_ext_clock_in), .serial_slave_select(serial_slave_select), .port_b_in(port_b_in),
  .port_b_out(port_b_out), .ext_irq_in(ext_irq_in), .wake_event(wake_event), .port_change_flag(port_change_flag),
  .port_c_out(port_c_out), .periph_override_en(periph_override_en), .periph_override_in(periph_override_in),
  .periph_out(periph_out));
`default_nettype wire

// [verification/gpc_pin_model.sv]
/*
  Board-side pin model for the three ports.
  Assumes the board drives every pin the block releases, port B only where enabled.
*/
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_model (
  input wire logic                clock,
  input wire gpc_pkg::gpc_pins6_s port_a_out,
  input wire gpc_pkg::gpc_pins8_s port_b_out,
  input wire gpc_pkg::gpc_pins6_s port_c_out,
  input wire logic [5:0]          ext_a,
  input wire logic [7:0]          ext_b,
  input wire logic [7:0]          ext_b_en,
  input wire logic [5:0]          ext_c,
  output logic [5:0]              port_a_in,
  output logic [7:0]              port_b_in,
  output logic [5:0]              port_c_in
);
  // A floating pin wanders so a stale value never reads as valid
  logic [7:0] wiggle = 8'h55;
  always @(posedge clock) wiggle <= ~wiggle;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!port_b_out.oe_n[i]) port_b_in[i] = port_b_out.drive[i];
      else if (ext_b_en[i]) port_b_in[i] = ext_b[i];
      else if (port_b_out.pullup_en[i]) port_b_in[i] = 1'b1;
      else port_b_in[i] = wiggle[i];
    end
  end
  assign port_a_in = (port_a_out.drive & ~port_a_out.oe_n) | (ext_a & port_a_out.oe_n);
  assign port_c_in = (port_c_out.drive & ~port_c_out.oe_n) | (ext_c & port_c_out.oe_n);
endmodule
`default_nettype wire

// [verification/gpc_gpio_ports_tb_top.sv]
/*
  Self-checking bench for the three-port GPIO block.
  Assumes the pin model on the far side and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module gpc_gpio_ports_tb_top;
  logic clock, arst_n, t0_clk, ss_in, irq_in, edge_sel, wake, flag;
  gpc_pkg::gpc_bus_s bus;
  gpc_pkg::gpc_pins6_s pa_out, pc_out;
  gpc_pkg::gpc_pins8_s pb_out;
  logic [7:0] rdata, pb_in, ext_b, ext_b_en;
  logic [5:0] pa_in, pc_in, a_sel, ov_en, ov_in, p_out, ext_a, ext_c;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  gpc_gpio_ports i_gpc_gpio_ports (.clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata), .port_a_in(pa_in),
    .port_a_out(pa_out), .port_a_analog_sel(a_sel), .timer_ext_clock_in(t0_clk), .serial_slave_select(ss_in),
    .port_b_in(pb_in), .port_b_out(pb_out), .ext_irq_in(irq_in), .irq_edge_select(edge_sel), .wake_event(wake),
    .port_change_flag(flag), .port_c_in(pc_in), .port_c_out(pc_out), .periph_override_en(ov_en),
    .periph_override_in(ov_in), .periph_out(p_out));
  gpc_pin_model i_gpc_pin_model (.clock(clock), .port_a_out(pa_out), .port_b_out(pb_out), .port_c_out(pc_out),
    .ext_a(ext_a), .ext_b(ext_b), .ext_b_en(ext_b_en), .ext_c(ext_c), .port_a_in(pa_in), .port_b_in(pb_in),
    .port_c_in(pc_in));
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e, input string m);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 check(rdata, e, m);
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_reset();
    rd_chk(gpc_pkg::OPTIONS_ADDR, 8'hFF, "option reset");
    rd_chk(gpc_pkg::PORT_A_DIRECTION_ADDR, 8'h3F, "A dir reset");
    rd_chk(gpc_pkg::PORT_B_DIRECTION_ADDR, 8'hFF, "B dir reset");
    rd_chk(gpc_pkg::ANALOG_PIN_CONFIG_ADDR, 8'h00, "config reset");
    rd_chk(gpc_pkg::PORT_A_PIN_DATA_ADDR, 8'h00, "A analog read");
    rd_chk(9'h010, 8'h00, "unmapped read");
    check(pb_out.pullup_en, 8'h00, "pull-ups at reset");
  endtask
  task automatic t_port_b();
    wr_reg(gpc_pkg::PORT_B_DIRECTION_ADDR, 8'h0F);
    wr_reg(gpc_pkg::PORT_B_PIN_DATA_ADDR, 8'hA5);
    #1 check(pb_out.oe_n, 8'h0F, "B direction");
    check(pb_out.drive, 8'hA5, "B latch");
    wr_reg(gpc_pkg::OPTIONS_ADDR, 8'h7F);
    #1 check(pb_out.pullup_en, 8'h0F, "pull-ups on inputs only");
    ext_b_en <= 8'h00;
    rd_chk(gpc_pkg::PORT_B_PIN_DATA_ADDR, 8'hAF, "B pins");
    ext_b_en <= 8'hFF;
    wr_reg(gpc_pkg::OPTIONS_ADDR, 8'hFF);
    wr_reg(gpc_pkg::PORT_B_DIRECTION_ADDR, 8'hFF);
  endtask
  task automatic t_change();
    rd_chk(gpc_pkg::PORT_B_PIN_DATA_ADDR, 8'h00, "B refresh");
    wr_reg(gpc_pkg::INTERRUPT_CONTROL_ADDR, 8'h00);
    ext_b <= 8'h04;
    wr_reg(gpc_pkg::PORT_B_DIRECTION_ADDR, 8'h7F);
    repeat (2) @(posedge clock);
    #1 check({7'h00, flag}, 8'h00, "lower and output pins ignored");
    ext_b <= 8'h24;
    #1 check({7'h00, wake}, 8'h01, "wake on change");
    // Flag is awaited without reading port B, which would hide the change
    @(posedge clock);
    #1 check({7'h00, flag}, 8'h01, "flag set");
    wr_reg(gpc_pkg::INTERRUPT_CONTROL_ADDR, 8'h00);
    #1 check({7'h00, flag}, 8'h01, "clear refused");
    rd_chk(gpc_pkg::PORT_B_PIN_DATA_ADDR, 8'hA4, "B read");
    check({7'h00, wake}, 8'h00, "read ends mismatch");
    wr_reg(gpc_pkg::INTERRUPT_CONTROL_ADDR, 8'h00);
    #1 check({7'h00, flag}, 8'h00, "flag cleared");
    ext_b <= 8'h64;
    wr_reg(gpc_pkg::PORT_B_PIN_DATA_ADDR, 8'hA5);
    #1 check({7'h00, wake}, 8'h00, "write ends mismatch");
  endtask
  task automatic t_port_a();
    logic [2:0] cfg [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
    logic [5:0] sel [5] = '{6'h3F, 6'h2F, 6'h0F, 6'h03, 6'h00};
    ext_a <= 6'h2A;
    for (int i = 0; i < 5; i++) begin
      wr_reg(gpc_pkg::ANALOG_PIN_CONFIG_ADDR, {5'h00, cfg[i]});
      #1 check({2'h0, a_sel}, {2'h0, sel[i]}, "analog select");
      rd_chk(gpc_pkg::PORT_A_PIN_DATA_ADDR, {2'h0, 6'h2A & ~sel[i]}, "A read");
    end
    wr_reg(gpc_pkg::PORT_A_DIRECTION_ADDR, 8'h00);
    wr_reg(gpc_pkg::PORT_A_PIN_DATA_ADDR, 8'h3F);
    #1 check({2'h0, pa_out.oe_n}, 8'h10, "open drain release");
    rd_chk(gpc_pkg::PORT_A_PIN_DATA_ADDR, 8'h2F, "A driven pins");
  endtask
  // Second reset in mid-run: options must fall back to pull-ups off
  task automatic t_rereset();
    wr_reg(gpc_pkg::OPTIONS_ADDR, 8'h3F);
    #1 check(pb_out.pullup_en, 8'h7F, "pull-ups before reset");
    check({7'h00, edge_sel}, 8'h00, "edge select follows option");
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1 check(pb_out.pullup_en, 8'h00, "pull-ups after reset");
    check({7'h00, edge_sel}, 8'h01, "edge select after reset");
    rd_chk(gpc_pkg::PORT_B_DIRECTION_ADDR, 8'hFF, "B dir after reset");
  endtask
  task automatic t_port_c();
    wr_reg(gpc_pkg::PORT_C_DIRECTION_ADDR, 8'hFF);
    rd_chk(gpc_pkg::PORT_C_DIRECTION_ADDR, 8'h3F, "C dir width");
    wr_reg(gpc_pkg::PORT_C_PIN_DATA_ADDR, 8'h15);
    // Whole-byte direction write, never a bit operation, done before the override is switched on
    wr_reg(gpc_pkg::PORT_C_DIRECTION_ADDR, 8'h00);
    ov_en <= 6'h03;
    ov_in <= 6'h01;
    p_out <= 6'h02;
    #1 check({2'h0, pc_out.oe_n}, 8'h01, "override direction");
    check({2'h0, pc_out.drive}, 8'h16, "override output");
    rd_chk(gpc_pkg::PORT_C_PIN_DATA_ADDR, 8'h16, "C pins");
  endtask
  // Run is about a hundred cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    arst_n = 1'b0;
    bus = '0;
    ext_a = 6'h3F;
    ext_b = 8'h00;
    ext_b_en = 8'hFF;
    ext_c = 6'h00;
    ov_en = 6'h00;
    ov_in = 6'h00;
    p_out = 6'h00;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_port_b();
    t_change();
    t_rereset();
    t_port_a();
    t_port_c();
    report_and_stop();
  end
endmodule
`default_nettype wire
